// [logic/ctr_timer_regs.sv]
// Function
// [RULE_01] pointer nibble zero selects normal file
// [RULE_02] nonzero nibble swaps low sixteen to bank
// [RULE_03] pointer high nibble picks working group
// [RULE_04] only banks 0, F, D exist
// [RULE_05] bank D locations 0-2 are controls
// [RULE_06] location 06 holds long reload low byte
// [RULE_07] location 05 holds short high count
// [RULE_08] location 04 holds short low count
// [RULE_09] short timer run bit starts/stops
// [RULE_10] short timer single-pass or repeat select
// [RULE_11] short timeout flag, write one clears
// [RULE_12] short timer prescale 1, 2, 4, 8
// [RULE_13] short capture interrupt mask
// [RULE_14] long timer run bit starts/stops
// [RULE_15] long single-pass or repeat in transmit
// [RULE_16] demodulation: bit 6 ignores later edges
// [RULE_17] long timeout flag, write one clears
// [RULE_18] long timer prescale 1, 2, 4, 8
// [RULE_19] long capture interrupt mask
// [RULE_20] long timeout interrupt mask
// [RULE_21] route bit zero gives port data
// [RULE_22] route bit one gives long timer output
// [RULE_23] long timer stops or reloads at zero
// [RULE_24] short timer toggles, reloads by level
// [RULE_25] software avoids count one; zero wraps
// [RULE_26] reserved location reads zero
module ctr_timer_regs (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // register access
  input ctr_pkg::ctr_req_s i_req,
  output logic [7:0] o_rdata,
  output ctr_pkg::ctr_route_s o_route,
  // timer events
  input wire logic i_t8_capture,
  input wire logic i_t16_edge,
  input wire logic i_port3_bit5_data,
  // outputs
  output logic o_short_timer_output,
  output logic o_long_timer_output,
  output logic o_port3_bit5_pin,
  output logic o_t8_timeout_irq,
  output logic o_t8_capture_irq,
  output logic o_t16_timeout_irq,
  output logic o_t16_capture_irq,
  output logic [15:0] o_t16_capture
);

  function automatic logic prescale_tick(input logic [1:0] sel,
                                         input logic [2:0] cnt);
    unique case (sel)
      ctr_pkg::DIV1: prescale_tick = 1'b1;
      ctr_pkg::DIV2: prescale_tick = cnt[0];
      ctr_pkg::DIV4: prescale_tick = &cnt[1:0];
      ctr_pkg::DIV8: prescale_tick = &cnt;
    endcase
  endfunction

  logic [7:0] bank_group_pointer_q, timer8_control_q, timer16_control_q;
  logic [7:0] timer_shared_control_q, timer8_low_hold_q, timer8_high_hold_q;
  logic [7:0] timer16_low_byte_hold_q, timer16_high_byte_hold_q;
  logic [2:0] prescale_q;
  logic [7:0] t8_count_q, t8_dec, eff_addr;
  logic [15:0] t16_count_q, t16_dec;
  logic t16_seen_edge_q, low_area, timer_hit, ptr_hit;
  logic [3:0] loc;
  logic wr_t8, wr_t16;
  logic t8_tick, t16_tick, t8_term, t16_term;
  logic t8_start, t16_start, demod, t16_take_edge;

  // address resolution
  always_comb
  begin
    eff_addr = i_req.short_addr ?
      {bank_group_pointer_q[7:4], i_req.addr[3:0]} : i_req.addr; // RULE_03
    low_area = (eff_addr[7:4] == 4'h0);
    timer_hit = low_area &&
      (bank_group_pointer_q[3:0] == ctr_pkg::BANK_TIMER); // RULE_02 RULE_04
    ptr_hit = (eff_addr == ctr_pkg::PTR_ADDR);
    loc = eff_addr[3:0];
  end

  assign wr_t8 = i_req.wr && timer_hit && (loc == ctr_pkg::LOC_T8_CTRL);
  assign wr_t16 = i_req.wr && timer_hit && (loc == ctr_pkg::LOC_T16_CTRL);

  // route the access to the register file or bank F
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_route <= '0;
    end
    else
    begin
      o_route.normal_sel <= (i_req.wr || i_req.rd) && !ptr_hit &&
        (!low_area ||
         bank_group_pointer_q[3:0] == ctr_pkg::BANK_NORMAL); // RULE_01
      o_route.bank_f_sel <= (i_req.wr || i_req.rd) && low_area &&
        (bank_group_pointer_q[3:0] == ctr_pkg::BANK_F); // RULE_04
      o_route.addr <= eff_addr;
    end
  end

  // pointer register
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      bank_group_pointer_q <= ctr_pkg::PTR_RESET;
    end
    else if (i_req.wr && ptr_hit)
    begin
      bank_group_pointer_q <= i_req.wdata;
    end
  end

  // hold registers
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      timer8_low_hold_q <= ctr_pkg::HOLD_RESET;
      timer8_high_hold_q <= ctr_pkg::HOLD_RESET;
      timer16_low_byte_hold_q <= ctr_pkg::HOLD_RESET;
      timer16_high_byte_hold_q <= ctr_pkg::HOLD_RESET;
      timer_shared_control_q <= ctr_pkg::CTRL_RESET;
    end
    else if (i_req.wr && timer_hit)
    begin
      unique case (loc)
        ctr_pkg::LOC_T8_LOW: timer8_low_hold_q <= i_req.wdata; // RULE_08
        ctr_pkg::LOC_T8_HIGH: timer8_high_hold_q <= i_req.wdata; // RULE_07
        ctr_pkg::LOC_T16_LOW:
          timer16_low_byte_hold_q <= i_req.wdata; // RULE_06
        ctr_pkg::LOC_T16_HIGH: timer16_high_byte_hold_q <= i_req.wdata;
        ctr_pkg::LOC_SHARED_CTRL: timer_shared_control_q <= i_req.wdata;
        default: ;
      endcase
    end
  end

  // read port
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_rdata <= 8'h00;
    end
    else if (i_req.rd)
    begin
      if (ptr_hit)
      begin
        o_rdata <= bank_group_pointer_q;
      end
      else if (timer_hit)
      begin
        unique case (loc)
          ctr_pkg::LOC_T8_CTRL: o_rdata <= timer8_control_q; // RULE_05
          ctr_pkg::LOC_SHARED_CTRL: o_rdata <= timer_shared_control_q;
          ctr_pkg::LOC_T16_CTRL: o_rdata <= timer16_control_q;
          ctr_pkg::LOC_T8_LOW: o_rdata <= timer8_low_hold_q;
          ctr_pkg::LOC_T8_HIGH: o_rdata <= timer8_high_hold_q;
          ctr_pkg::LOC_T16_LOW: o_rdata <= timer16_low_byte_hold_q;
          ctr_pkg::LOC_T16_HIGH: o_rdata <= timer16_high_byte_hold_q;
          default: o_rdata <= 8'h00; // RULE_26
        endcase
      end
      else
      begin
        o_rdata <= 8'h00;
      end
    end
  end

  // shared prescaler
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      prescale_q <= ctr_pkg::PRESCALE_RESET;
    end
    else
    begin
      prescale_q <= prescale_q + 3'h1;
    end
  end

  assign t8_tick = prescale_tick(
    timer8_control_q[ctr_pkg::BIT_CLK_HI:ctr_pkg::BIT_CLK_LO],
    prescale_q); // RULE_12
  assign t16_tick = prescale_tick(
    timer16_control_q[ctr_pkg::BIT_CLK_HI:ctr_pkg::BIT_CLK_LO],
    prescale_q); // RULE_18
  assign t8_dec = t8_count_q - 8'h01;
  assign t16_dec = t16_count_q - 16'h0001;
  // zero start wraps to the top without a timeout
  assign t8_term = timer8_control_q[ctr_pkg::BIT_RUN] && t8_tick &&
    (t8_dec == 8'h00); // RULE_25
  assign t16_term = timer16_control_q[ctr_pkg::BIT_RUN] && !demod &&
    t16_tick && (t16_dec == 16'h0000); // RULE_25
  assign t8_start = wr_t8 && i_req.wdata[ctr_pkg::BIT_RUN] &&
    !timer8_control_q[ctr_pkg::BIT_RUN];
  assign t16_start = wr_t16 && i_req.wdata[ctr_pkg::BIT_RUN] &&
    !timer16_control_q[ctr_pkg::BIT_RUN];
  assign demod = timer_shared_control_q[ctr_pkg::BIT_DEMOD];
  assign t16_take_edge = timer16_control_q[ctr_pkg::BIT_RUN] && demod &&
    i_t16_edge &&
    (!t16_seen_edge_q || !timer16_control_q[ctr_pkg::BIT_SINGLE]); // RULE_16

  // short timer control register
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      timer8_control_q <= ctr_pkg::CTRL_RESET;
    end
    else
    begin
      if (wr_t8)
      begin
        timer8_control_q[ctr_pkg::BIT_RUN] <=
          i_req.wdata[ctr_pkg::BIT_RUN]; // RULE_09
        timer8_control_q[ctr_pkg::BIT_SINGLE] <=
          i_req.wdata[ctr_pkg::BIT_SINGLE]; // RULE_10
        timer8_control_q[4:0] <= i_req.wdata[4:0]; // RULE_12 RULE_13
      end
      else if (t8_term && timer8_control_q[ctr_pkg::BIT_SINGLE])
      begin
        timer8_control_q[ctr_pkg::BIT_RUN] <= 1'b0;
      end
      // a timeout in the clearing cycle survives
      if (t8_term)
      begin
        timer8_control_q[ctr_pkg::BIT_TIMEOUT] <= 1'b1; // RULE_11
      end
      else if (wr_t8 && i_req.wdata[ctr_pkg::BIT_TIMEOUT])
      begin
        timer8_control_q[ctr_pkg::BIT_TIMEOUT] <= 1'b0; // RULE_11
      end
    end
  end

  // short timer counter and output
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      t8_count_q <= 8'h00;
      o_short_timer_output <= 1'b0;
    end
    else if (t8_start)
    begin
      o_short_timer_output <=
        timer_shared_control_q[ctr_pkg::BIT_T8_INIT];
      t8_count_q <= timer_shared_control_q[ctr_pkg::BIT_T8_INIT] ?
        timer8_high_hold_q : timer8_low_hold_q;
    end
    else if (t8_term)
    begin
      o_short_timer_output <= !o_short_timer_output; // RULE_24
      t8_count_q <= o_short_timer_output ?
        timer8_low_hold_q : timer8_high_hold_q; // RULE_24
    end
    else if (timer8_control_q[ctr_pkg::BIT_RUN] && t8_tick)
    begin
      t8_count_q <= t8_dec;
    end
  end

  // long timer control register
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      timer16_control_q <= ctr_pkg::CTRL_RESET;
    end
    else
    begin
      if (wr_t16)
      begin
        timer16_control_q[ctr_pkg::BIT_RUN] <=
          i_req.wdata[ctr_pkg::BIT_RUN]; // RULE_14
        timer16_control_q[ctr_pkg::BIT_SINGLE] <=
          i_req.wdata[ctr_pkg::BIT_SINGLE]; // RULE_15
        timer16_control_q[4:0] <=
          i_req.wdata[4:0]; // RULE_18 RULE_19 RULE_20 RULE_21
      end
      else if (t16_term && timer16_control_q[ctr_pkg::BIT_SINGLE])
      begin
        timer16_control_q[ctr_pkg::BIT_RUN] <= 1'b0; // RULE_23
      end
      if (t16_term)
      begin
        timer16_control_q[ctr_pkg::BIT_TIMEOUT] <= 1'b1; // RULE_17
      end
      else if (wr_t16 && i_req.wdata[ctr_pkg::BIT_TIMEOUT])
      begin
        timer16_control_q[ctr_pkg::BIT_TIMEOUT] <= 1'b0; // RULE_17
      end
    end
  end

  // long timer counter, capture and output
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      t16_count_q <= 16'h0000;
      t16_seen_edge_q <= 1'b0;
      o_t16_capture <= 16'h0000;
      o_long_timer_output <= 1'b0;
    end
    else if (t16_start)
    begin
      t16_seen_edge_q <= 1'b0;
      o_long_timer_output <=
        timer_shared_control_q[ctr_pkg::BIT_T16_INIT];
      t16_count_q <= {timer16_high_byte_hold_q, timer16_low_byte_hold_q};
    end
    else if (t16_take_edge)
    begin
      t16_seen_edge_q <= 1'b1;
      if (t16_seen_edge_q)
      begin
        o_t16_capture <= ~t16_count_q;
      end
      t16_count_q <= 16'hffff;
    end
    else if (t16_term)
    begin
      o_long_timer_output <= !o_long_timer_output;
      // single pass holds at zero, repeat reloads
      t16_count_q <= timer16_control_q[ctr_pkg::BIT_SINGLE] ? 16'h0000 :
        {timer16_high_byte_hold_q, timer16_low_byte_hold_q}; // RULE_23
    end
    else if (timer16_control_q[ctr_pkg::BIT_RUN] && t16_tick)
    begin
      t16_count_q <= t16_dec;
    end
  end

  // interrupt requests and pin
  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      o_t8_timeout_irq <= 1'b0;
      o_t8_capture_irq <= 1'b0;
      o_t16_timeout_irq <= 1'b0;
      o_t16_capture_irq <= 1'b0;
      o_port3_bit5_pin <= 1'b0;
    end
    else
    begin
      o_t8_timeout_irq <= t8_term &&
        timer8_control_q[ctr_pkg::BIT_TO_MASK];
      o_t8_capture_irq <= i_t8_capture &&
        timer8_control_q[ctr_pkg::BIT_CAP_MASK]; // RULE_13
      o_t16_timeout_irq <= t16_term &&
        timer16_control_q[ctr_pkg::BIT_TO_MASK]; // RULE_20
      o_t16_capture_irq <= t16_take_edge && t16_seen_edge_q &&
        timer16_control_q[ctr_pkg::BIT_CAP_MASK]; // RULE_19
      o_port3_bit5_pin <= timer16_control_q[ctr_pkg::BIT_PIN_ROUTE] ?
        o_long_timer_output : i_port3_bit5_data; // RULE_21 RULE_22
    end
  end
endmodule

// [include/ctr_pkg.sv]
package ctr_pkg;

  // register file addresses
  localparam logic [7:0] PTR_ADDR = 8'hfd;

  // expanded bank codes held in the pointer low nibble
  localparam logic [3:0] BANK_NORMAL = 4'h0;
  localparam logic [3:0] BANK_TIMER = 4'hd;
  localparam logic [3:0] BANK_F = 4'hf;

  // locations inside the timer bank
  localparam logic [3:0] LOC_T8_CTRL = 4'h0;
  localparam logic [3:0] LOC_SHARED_CTRL = 4'h1;
  localparam logic [3:0] LOC_T16_CTRL = 4'h2;
  localparam logic [3:0] LOC_RESERVED = 4'h3;
  localparam logic [3:0] LOC_T8_LOW = 4'h4;
  localparam logic [3:0] LOC_T8_HIGH = 4'h5;
  localparam logic [3:0] LOC_T16_LOW = 4'h6;
  localparam logic [3:0] LOC_T16_HIGH = 4'h7;

  // control register fields, shared by both timer control registers
  localparam int BIT_RUN = 7;
  localparam int BIT_SINGLE = 6;
  localparam int BIT_TIMEOUT = 5;
  localparam int BIT_CLK_HI = 4;
  localparam int BIT_CLK_LO = 3;
  localparam int BIT_CAP_MASK = 2;
  localparam int BIT_TO_MASK = 1;
  localparam int BIT_PIN_ROUTE = 0;

  // shared control fields
  localparam int BIT_DEMOD = 7;
  localparam int BIT_T8_INIT = 1;
  localparam int BIT_T16_INIT = 0;

  // values after reset
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [7:0] HOLD_RESET = 8'h00;
  localparam logic [2:0] PRESCALE_RESET = 3'h0;

  // prescale codes
  localparam logic [1:0] DIV1 = 2'h0;
  localparam logic [1:0] DIV2 = 2'h1;
  localparam logic [1:0] DIV4 = 2'h2;
  localparam logic [1:0] DIV8 = 2'h3;

  // register access request from the core
  typedef struct packed {
    logic wr;
    logic rd;
    logic short_addr;
    logic [7:0] addr;
    logic [7:0] wdata;
  } ctr_req_s;

  // resolved register file target
  typedef struct packed {
    logic normal_sel;
    logic bank_f_sel;
    logic [7:0] addr;
  } ctr_route_s;

endpackage

// [verification/ctr_timer_regs_sva.sv]
module ctr_timer_regs_sva (
  // clock and reset
  input wire logic i_clk,
  input wire logic i_srst,
  // register access
  input ctr_pkg::ctr_req_s i_req,
  input logic [7:0] o_rdata,
  input ctr_pkg::ctr_route_s o_route,
  // pin and timer
  input wire logic i_port3_bit5_data,
  input logic o_long_timer_output,
  input logic o_port3_bit5_pin,
  input logic o_t16_timeout_irq
);
  logic [7:0] ptr_q;
  logic [7:0] h4_q;
  logic [7:0] h5_q;
  logic [7:0] h6_q;
  logic [7:0] hsel;
  logic [7:0] eff;
  logic rt_q;
  logic acc;
  logic low;
  logic bd;

  // shadow of pointer, hold bytes and pin route bit
  assign acc = i_req.wr | i_req.rd;
  assign eff = i_req.short_addr ? {ptr_q[7:4], i_req.addr[3:0]} : i_req.addr;
  assign low = eff[7:4] == 4'h0;
  assign bd = low && ptr_q[3:0] == ctr_pkg::BANK_TIMER;
  assign hsel = (eff[3:0] == ctr_pkg::LOC_T8_LOW) ? h4_q :
    (eff[3:0] == ctr_pkg::LOC_T8_HIGH) ? h5_q : h6_q;

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
      ptr_q <= ctr_pkg::PTR_RESET;
    else if (i_req.wr && eff == ctr_pkg::PTR_ADDR)
      ptr_q <= i_req.wdata;
  end

  always_ff @(posedge i_clk)
  begin
    if (i_srst)
    begin
      h4_q <= 8'h00;
      h5_q <= 8'h00;
      h6_q <= 8'h00;
      rt_q <= 1'b0;
    end
    else if (i_req.wr && bd)
    begin
      if (eff[3:0] == ctr_pkg::LOC_T8_LOW)
        h4_q <= i_req.wdata;
      if (eff[3:0] == ctr_pkg::LOC_T8_HIGH)
        h5_q <= i_req.wdata;
      if (eff[3:0] == ctr_pkg::LOC_T16_LOW)
        h6_q <= i_req.wdata;
      if (eff[3:0] == ctr_pkg::LOC_T16_CTRL)
        rt_q <= i_req.wdata[ctr_pkg::BIT_PIN_ROUTE];
    end
  end

  default clocking @(posedge i_clk); endclocking
  default disable iff (i_srst);

  route_normal_a: assert property (acc && low && ptr_q[3:0] == 4'h0
    |=> o_route.normal_sel) else $error("normal file not selected");
  route_bank_a: assert property (acc && bd
    |=> !o_route.normal_sel && !o_route.bank_f_sel)
    else $error("timer bank not selected");
  group_addr_a: assert property (acc
    |=> o_route.addr == $past(eff)) else $error("resolved address wrong");
  bank_f_a: assert property (acc && low && ptr_q[3:0] == 4'hf
    |=> o_route.bank_f_sel && !o_route.normal_sel)
    else $error("bank f not flagged");
  hold_read_a: assert property (i_req.rd && bd &&
    eff[3:0] inside {4, 5, 6} |=> o_rdata == $past(hsel))
    else $error("hold byte read wrong");
  reserved_zero_a: assert property (i_req.rd && bd &&
    eff[3:0] == 4'h3 |=> o_rdata == 8'h00)
    else $error("reserved location not zero");
  pin_port_a: assert property (!rt_q && !$past(i_srst)
    |=> o_port3_bit5_pin == $past(i_port3_bit5_data))
    else $error("pin not following port data");
  pin_timer_a: assert property (rt_q && !$past(i_srst)
    |=> o_port3_bit5_pin == $past(o_long_timer_output))
    else $error("pin not following timer output");
  irq_pulse_a: assert property (o_t16_timeout_irq
    |=> !o_t16_timeout_irq) else $error("timeout pulse too long");
endmodule

// [verification/testbench.sv]
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin miscompares++; \
  $display("wrong value at %0t: got %0h want %0h", $time, a, b); end end

module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  logic i_clk;
  logic i_srst;
  logic t8c;
  logic t16e;
  logic [7:0] pl = 8'h5a;
  wire pdat = pl[0];
  ctr_pkg::ctr_req_s req;
  ctr_pkg::ctr_route_s route;
  logic [7:0] rdata;
  logic so, lo, pin, i0, i1, i2, i3;
  logic [15:0] cap;
  int miscompares = 0;
  int checks_done = 0;
  logic [31:0] seed = 32'h0bf4;

  ctr_timer_regs ctr_timer_regs_inst (.i_clk(i_clk), .i_srst(i_srst),
    .i_req(req), .o_rdata(rdata), .o_route(route), .i_t8_capture(t8c),
    .i_t16_edge(t16e), .i_port3_bit5_data(pdat),
    .o_short_timer_output(so), .o_long_timer_output(lo),
    .o_port3_bit5_pin(pin), .o_t8_timeout_irq(i0), .o_t8_capture_irq(i1),
    .o_t16_timeout_irq(i2), .o_t16_capture_irq(i3), .o_t16_capture(cap));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic final_report();
    $display("checks %0d mismatches %0d", checks_done, miscompares);
    if (miscompares == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(negedge i_clk);
    req = '{wr: w, rd: !w, short_addr: 1'b0, addr: a, wdata: d};
    @(negedge i_clk);
    req = '0;
    if (!w)
      @(negedge i_clk);
  endtask

  task automatic pulse(input logic t16);
    @(negedge i_clk);
    if (t16)
      t16e = 1'b1;
    else
      t8c = 1'b1;
    @(negedge i_clk);
    t16e = 1'b0;
    t8c = 1'b0;
  endtask

  // counts cycles until the chosen output shows lv; hard waits must see it
  task automatic wait_for(input int w, input logic lv, input int lim,
                          input bit hard, output int n);
    logic s;
    n = 0;
    do
    begin
      @(negedge i_clk);
      n++;
      s = (w == 0) ? i2 : (w == 1) ? so : (w == 2) ? i3 : i0;
    end while (s !== lv && n < lim);
    if (hard && s !== lv)
    begin
      miscompares++;
      final_report();
    end
  endtask

  initial
  begin
    i_clk = 1'b0;
    forever #10 i_clk = ~i_clk;
  end

  always @(negedge i_clk)
    pl <= {pl[6:0], pl[7] ^ pl[5] ^ pl[4] ^ pl[3]};

  initial
  begin
    repeat (90000) @(posedge i_clk);
    miscompares++;
    final_report();
  end

  initial
  begin
    int n;
    logic [7:0] v;
    logic [31:0] r;
    i_srst = 1'b1;
    req = '0;
    t8c = 1'b0;
    t16e = 1'b0;
    repeat (4) @(posedge i_clk);
    @(negedge i_clk);
    i_srst = 1'b0;
    acc(1, 8'hfd, 8'h0d);
    for (int a = 0; a < 8; a++)
    begin
      acc(0, 8'(a), 8'h00);
      `CHK(rdata, 8'h00)
    end
    for (int a = 3; a < 8; a++)
    begin
      r = xs();
      acc(1, 8'(a), r[7:0]);
      acc(0, 8'(a), 8'h00);
      `CHK(rdata, a == 3 ? 8'h00 : r[7:0])
    end
    for (int c = 0; c < 8; c++)
    begin
      r = xs();
      v = {1'b0, r[6], 1'b0, c[1:0], r[2:0]};
      acc(1, {6'h00, c[2], 1'b0}, v);
      acc(0, {6'h00, c[2], 1'b0}, 8'h00);
      `CHK(rdata, v)
    end
    acc(1, 8'h00, 8'h00);
    acc(1, 8'h06, 8'h05);
    acc(1, 8'h07, 8'h00);
    for (int c = 0; c < 4; c++)
    begin
      acc(1, 8'h02, {3'b100, c[1:0], 3'b011});
      wait_for(0, 1'b1, 2000, 1'b1, n);
      wait_for(0, 1'b1, 2000, 1'b1, n);
      `CHK(n, 5 << c)
      acc(1, 8'h02, {3'b000, c[1:0], 3'b011});
      acc(0, 8'h02, 8'h00);
      `CHK(rdata, {3'b001, c[1:0], 3'b011})
      acc(1, 8'h02, {3'b001, c[1:0], 3'b011});
      acc(0, 8'h02, 8'h00);
      `CHK(rdata, {3'b000, c[1:0], 3'b011})
      wait_for(0, 1'b1, 40, 1'b0, n);
      `CHK(n, 40)
    end
    acc(1, 8'h06, 8'h04);
    acc(1, 8'h02, 8'hc2);
    wait_for(0, 1'b1, 200, 1'b1, n);
    acc(0, 8'h02, 8'h00);
    `CHK(rdata, 8'h62)
    acc(1, 8'h02, 8'h20);
    acc(1, 8'h04, 8'h03);
    acc(1, 8'h05, 8'h06);
    for (int c = 0; c < 4; c++)
    begin
      acc(1, 8'h00, {3'b100, c[1:0], 3'b000});
      wait_for(1, 1'b1, 2000, 1'b1, n);
      wait_for(1, 1'b0, 2000, 1'b1, n);
      `CHK(n, 6 << c)
      wait_for(1, 1'b1, 2000, 1'b1, n);
      `CHK(n, 3 << c)
      acc(1, 8'h00, 8'h20);
    end
    // single pass with timeout interrupt: low hold count, then stop
    acc(1, 8'h00, 8'hc2);
    wait_for(3, 1'b1, 50, 1'b1, n);
    `CHK(n, 3)
    acc(0, 8'h00, 8'h00);
    `CHK(rdata, 8'h62)
    acc(1, 8'h00, 8'h20);
    for (int m = 0; m < 2; m++)
    begin
      acc(1, 8'h00, {5'h00, m[0], 2'b00});
      pulse(1'b0);
      `CHK(i1, m[0])
    end
    acc(1, 8'h01, 8'h80);
    acc(1, 8'h06, 8'hff);
    acc(1, 8'h07, 8'hff);
    for (int s = 0; s < 2; s++)
    begin
      acc(1, 8'h02, {1'b1, s[0], 6'h04});
      pulse(1'b1);
      repeat (5) @(negedge i_clk);
      pulse(1'b1);
      `CHK(i3, !s[0])
      `CHK(cap, 16'h0006)
      acc(1, 8'h02, 8'h20);
    end
    acc(1, 8'h01, 8'h00);
    for (int p = 0; p < 2; p++)
    begin
      acc(1, 8'hfd, p == 1 ? 8'h3f : 8'h30);
      repeat (40)
      begin
        @(negedge i_clk);
        r = xs();
        req = '{wr: r[0], rd: r[1], short_addr: r[2], addr: {1'b0, r[14:8]},
          wdata: r[23:16]};
      end
      @(negedge i_clk);
      req = '0;
    end
    final_report();
  end
endmodule

bind ctr_timer_regs ctr_timer_regs_sva ctr_timer_regs_sva_inst (
  .i_clk(i_clk), .i_srst(i_srst), .i_req(i_req), .o_rdata(o_rdata),
  .o_route(o_route), .i_port3_bit5_data(i_port3_bit5_data),
  .o_long_timer_output(o_long_timer_output),
  .o_port3_bit5_pin(o_port3_bit5_pin),
  .o_t16_timeout_irq(o_t16_timeout_irq));
